/* pkg/fcp_pkg.sv */
/*
  Shared constants for flash content protection: register offsets, reset
  values, command codes and range geometry.
  Assumes an 8-bit register space with 16-bit addresses, one clock domain.
*/
`default_nettype none
package fcp_pkg;
  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [15:0] FCP_ADDR_TOP     = 16'hA012;
  localparam logic [15:0] FCP_ADDR_GUARD_LO = 16'hA013;
  localparam logic [15:0] FCP_ADDR_GUARD_HI = 16'hA014;
  localparam logic [15:0] FCP_ADDR_DATA    = 16'hA021;
  localparam logic [15:0] FCP_ADDR_HIGH    = 16'hA022;
  localparam logic [15:0] FCP_ADDR_LOW     = 16'hA023;
  localparam logic [15:0] FCP_ADDR_LZONE   = 16'hA025;
  localparam logic [15:0] FCP_ADDR_UZONE   = 16'hA026;
  localparam logic [15:0] FCP_ADDR_CMD     = 16'hA027;
  localparam logic [15:0] FCP_ADDR_STAT    = 16'hA028;
  localparam logic [15:0] FCP_ADDR_IMASK   = 16'hA029;
  localparam logic [15:0] FCP_ADDR_RESULT  = 16'hA02A;
  // ****************************************************
  // Reset values and fields
  // ****************************************************
  localparam logic [7:0] FCP_RST_ZERO  = 8'h00;
  localparam logic [7:0] FCP_RST_LZONE = 8'hFF;
  localparam logic [7:0] FCP_RST_UZONE = 8'h00;
  localparam int         FCP_UPD_EN_BIT = 7;
  localparam logic [7:0] FCP_UPD_EN_WORD = 8'h80;
  localparam logic [7:0] FCP_RANGE_MASK_HI = 8'h7F;
  localparam logic [7:0] FCP_TOP_PAGE = 8'hFF;
  // ****************************************************
  // Commands (low two bits of the command register)
  // ****************************************************
  localparam logic [1:0] FCP_CMD_READ  = 2'h1;
  localparam logic [1:0] FCP_CMD_WRITE = 2'h2;
  localparam logic [1:0] FCP_CMD_ERASE = 2'h3;
  // Status bits: 0 done, 1 fail
  localparam int FCP_ST_DONE = 0;
  localparam int FCP_ST_FAIL = 1;
  // Read guard ranges start at (index+1) * 4 KiB, index 0..14
  localparam int FCP_GUARD_RANGES = 15;
endpackage
`default_nettype wire

/* pkg/fcp_if.sv */
/*
  Interface joining the CPU-side register master and the protection device.
  Assumes both ends share clock and reset_n.
*/
`timescale 1ns/1ns
`default_nettype none
interface fcp_if (
  input wire logic clock,
  input wire logic reset_n
);
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        code_rd;
  logic [15:0] code_addr;
  logic [7:0]  code_data;
  logic        irq;
  modport dev  (input addr, wdata, wr, rd, code_rd, code_addr, output rdata, code_data, irq);
  modport host (output addr, wdata, wr, rd, code_rd, code_addr, input rdata, code_data, irq);
endinterface
`default_nettype wire

/* rtl/fcp_device.sv */
/*
  Flash content protection device: address registers, erase/write zone check,
  write-once read guard, command result and interrupt.
  Assumes the flash array returns read data one cycle after fl_rd and that
  reset_n is the OR of all chip reset sources.
*/
// Contract
// RULE1 - Check every command address against zones (code checks only write and erase commands; reads are not checked)
// RULE2 - Two zones: bottom and top of space
// RULE3 - Low boundary in pages, below value protected
// RULE4 - Low boundary resets all ones
// RULE5 - Upper pages above boundary plus one protected
// RULE6 - Guarded reads return zero
// RULE7 - Guard registers cleared only by reset
// RULE8 - Guard bits set-only
// RULE9 - Write 0x80 enables range updates
// RULE10 - Range set clears enable until reset
// RULE11 - Low guard bit n from (n+1)*4K
// RULE12 - High guard bit n from (n+9)*4K
// RULE13 - Software avoids ranges at 0x08000 up
// RULE14 - High address byte register read/write
// RULE15 - Software never executes in guarded zone
// RULE16 - Address from top, high, low registers
// RULE17 - Protected erase/write skipped, fail set
// RULE18 - Lowest selected start address wins
`timescale 1ns/1ns
`default_nettype none
module fcp_device
  import fcp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Register side
  fcp_if.dev               bus,
  // Flash array side
  output logic             fl_rd,
  output logic             fl_wr,
  output logic             fl_erase,
  output logic [23:0]      fl_addr,
  output logic [7:0]       fl_wdata,
  input  wire logic [7:0]  fl_rdata
);
  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [4:0] guard_start(input logic [14:0] sel);
    logic [4:0] r;
    r = 5'h10;
    for (int i = FCP_GUARD_RANGES - 1; i >= 0; i--) begin
      if (sel[i]) begin
        r = 5'(i + 1); // RULE18
      end
    end
    return r;
  endfunction

  function automatic logic guarded(input logic [23:0] a, input logic [4:0] start);
    // RULE11 RULE12
    return (start != 5'h10) && (a[23:16] == 8'h00) && ({1'b0, a[15:12]} >= start);
  endfunction

  // ****************************************************
  // Registers
  // ****************************************************
  logic [7:0] top_q, high_q, low_q, data_q, lzone_q, uzone_q;
  logic [7:0] glo_q, ghi_q, stat_q, imask_q, rdata_q, code_q;
  logic       upd_en_q, res_fail_q, code_pend_q, code_ans_q, irq_q;
  logic [1:0] cmd_rd_q;
  logic       fl_rd_q, fl_wr_q, fl_erase_q, guard_hit_q, code_guard_q;

  wire        wr_top   = bus.wr && bus.addr == FCP_ADDR_TOP;
  wire        wr_glo   = bus.wr && bus.addr == FCP_ADDR_GUARD_LO;
  wire        wr_ghi   = bus.wr && bus.addr == FCP_ADDR_GUARD_HI;
  wire        wr_cmd   = bus.wr && bus.addr == FCP_ADDR_CMD;
  wire [23:0] cmd_addr = {top_q, high_q, low_q}; // RULE16
  wire [1:0]  cmd_op   = bus.wdata[1:0];
  wire [7:0]  page     = cmd_addr[15:8];
  // RULE2 RULE3 RULE4
  wire        in_lzone = (cmd_addr[23:16] == 8'h00) && (page < lzone_q);
  // RULE2 RULE5
  wire        in_uzone = (cmd_addr[23:16] != 8'h00) || ({1'b0, page} > {1'b0, uzone_q} + 9'h001);
  wire        modify   = (cmd_op == FCP_CMD_WRITE) || (cmd_op == FCP_CMD_ERASE);
  wire        blocked  = modify && (in_lzone || in_uzone); // RULE1 RULE17
  wire [4:0]  gstart   = guard_start({ghi_q[6:0], glo_q});
  wire [7:0]  glo_set  = glo_q | (upd_en_q ? bus.wdata : FCP_RST_ZERO); // RULE8 RULE9
  wire [7:0]  ghi_set  = ghi_q | (upd_en_q ? (bus.wdata & FCP_RANGE_MASK_HI) : FCP_RST_ZERO);
  wire        range_wr = upd_en_q && ((wr_glo && bus.wdata != 8'h00)
                         || (wr_ghi && (bus.wdata & FCP_RANGE_MASK_HI) != 8'h00));
  wire        ev_done  = wr_cmd && cmd_op != 2'h0;
  wire        ev_fail  = wr_cmd && blocked;
  wire [7:0]  ev_vec   = {6'h00, ev_fail, ev_done};
  wire        stat_clr_wr = bus.wr && bus.addr == FCP_ADDR_STAT;
  wire [7:0]  stat_d   = (stat_q & ~(stat_clr_wr ? bus.wdata : 8'h00)) | ev_vec;

  // ****************************************************
  // Read mux
  // ****************************************************
  logic [7:0] rmux;
  always_comb begin
    case (bus.addr)
      FCP_ADDR_TOP:      rmux = top_q;
      FCP_ADDR_GUARD_LO: rmux = glo_q;
      FCP_ADDR_GUARD_HI: rmux = {upd_en_q, ghi_q[6:0]};
      FCP_ADDR_DATA:     rmux = data_q;
      FCP_ADDR_HIGH:     rmux = high_q; // RULE14
      FCP_ADDR_LOW:      rmux = low_q;
      FCP_ADDR_LZONE:    rmux = lzone_q;
      FCP_ADDR_UZONE:    rmux = uzone_q;
      FCP_ADDR_STAT:     rmux = stat_q;
      FCP_ADDR_IMASK:    rmux = imask_q;
      FCP_ADDR_RESULT:   rmux = {7'h00, res_fail_q};
      default:           rmux = 8'h00;
    endcase
  end

  // ****************************************************
  // State
  // ****************************************************
  // Only reset clears the guard; no write path can lower a bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      glo_q    <= FCP_RST_ZERO; // RULE7
      ghi_q    <= FCP_RST_ZERO;
      upd_en_q <= 1'b0;
    end else begin
      if (wr_glo) begin
        glo_q <= glo_set;
      end
      if (wr_ghi) begin
        ghi_q <= ghi_set;
      end
      if (range_wr) begin
        upd_en_q <= 1'b0; // RULE10
      end else if (wr_ghi && bus.wdata[FCP_UPD_EN_BIT] && gstart == 5'h10) begin
        upd_en_q <= 1'b1; // RULE9
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      top_q <= FCP_RST_ZERO;
      high_q <= FCP_RST_ZERO;
      low_q <= FCP_RST_ZERO;
      data_q <= FCP_RST_ZERO;
      lzone_q <= FCP_RST_LZONE; // RULE4
      uzone_q <= FCP_RST_UZONE;
      stat_q <= FCP_RST_ZERO;
      imask_q <= FCP_RST_ZERO;
      res_fail_q <= 1'b0;
    end else begin
      if (wr_top) top_q <= bus.wdata;
      if (bus.wr && bus.addr == FCP_ADDR_HIGH) high_q <= bus.wdata; // RULE14
      if (bus.wr && bus.addr == FCP_ADDR_LOW) low_q <= bus.wdata;
      if (bus.wr && bus.addr == FCP_ADDR_DATA) data_q <= bus.wdata;
      else if (cmd_rd_q[1]) data_q <= guard_hit_q ? FCP_RST_ZERO : fl_rdata; // RULE6 RULE16
      if (bus.wr && bus.addr == FCP_ADDR_LZONE) lzone_q <= bus.wdata;
      if (bus.wr && bus.addr == FCP_ADDR_UZONE) uzone_q <= bus.wdata;
      if (bus.wr && bus.addr == FCP_ADDR_IMASK) imask_q <= bus.wdata;
      stat_q <= stat_d; // Set wins over clear
      if (ev_done) res_fail_q <= blocked; // RULE17
    end
  end

  // Flash strobes: a blocked command never reaches the array
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fl_rd_q <= 1'b0;
      fl_wr_q <= 1'b0;
      fl_erase_q <= 1'b0;
      cmd_rd_q <= 2'h0;
      guard_hit_q <= 1'b0;
    end else begin
      fl_rd_q <= (wr_cmd && cmd_op == FCP_CMD_READ) || bus.code_rd;
      fl_wr_q <= wr_cmd && cmd_op == FCP_CMD_WRITE && !blocked; // RULE17
      fl_erase_q <= wr_cmd && cmd_op == FCP_CMD_ERASE && !blocked;
      // Array answers in the cycle after its strobe; capture then, not live
      cmd_rd_q <= {cmd_rd_q[0], wr_cmd && cmd_op == FCP_CMD_READ};
      if (wr_cmd && cmd_op == FCP_CMD_READ) guard_hit_q <= guarded(cmd_addr, gstart); // RULE6
    end
  end

  // Code fetch read: data returns three cycles after the request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      code_pend_q <= 1'b0;
      code_ans_q <= 1'b0;
      code_guard_q <= 1'b0;
      code_q <= FCP_RST_ZERO;
      rdata_q <= FCP_RST_ZERO;
      irq_q <= 1'b0;
    end else begin
      code_pend_q <= bus.code_rd;
      code_ans_q <= code_pend_q;
      if (bus.code_rd) code_guard_q <= guarded({8'h00, bus.code_addr}, gstart);
      if (code_ans_q) code_q <= code_guard_q ? 8'h00 : fl_rdata; // RULE6
      rdata_q <= bus.rd ? rmux : 8'h00;
      irq_q <= |(stat_d & imask_q);
    end
  end

  wire [23:0] code_full = {8'h00, bus.code_addr};
  logic [23:0] fl_addr_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) fl_addr_q <= 24'h000000;
    else if (bus.code_rd) fl_addr_q <= code_full;
    else if (wr_cmd) fl_addr_q <= cmd_addr; // RULE16
  end

  assign bus.rdata = rdata_q;
  assign bus.code_data = code_q;
  assign bus.irq = irq_q;
  assign fl_rd = fl_rd_q;
  assign fl_wr = fl_wr_q;
  assign fl_erase = fl_erase_q;
  assign fl_addr = fl_addr_q;
  assign fl_wdata = data_q;
endmodule // fcp_device
`default_nettype wire

/* rtl/fcp_host.sv */
/*
  CPU-side end: turns user requests into register strobes and code fetches.
  Assumes the user raises one request at a time and waits for done; code fetches raise no done.
*/
`timescale 1ns/1ns
`default_nettype none
module fcp_host
  import fcp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Link
  fcp_if.host              bus,
  // User side
  input  wire logic        req,
  input  wire logic [1:0]  kind,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             done,
  output logic [7:0]       rsp_data,
  output logic             irq_seen
);
  // kind: 0 reg write, 1 reg read, 2 code fetch (RULE13 RULE15 are software duties)
  typedef enum {S_IDLE, S_WAIT1, S_WAIT2, S_WAIT3, S_WAIT4} fcp_state_type;
  fcp_state_type st_q;
  logic [1:0]  kind_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q, rsp_q;
  logic        wr_q, rd_q, crd_q, done_q, irq_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      kind_q <= 2'h0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      crd_q <= 1'b0;
      done_q <= 1'b0;
      rsp_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      crd_q <= 1'b0;
      done_q <= 1'b0;
      irq_q <= bus.irq;
      case (st_q)
        S_IDLE: if (req) begin
          kind_q <= kind;
          addr_q <= req_addr;
          wdata_q <= req_wdata;
          wr_q <= kind == 2'h0;
          rd_q <= kind == 2'h1;
          crd_q <= kind == 2'h2;
          st_q <= S_WAIT1;
        end
        S_WAIT1: begin
          if (kind_q == 2'h0) begin
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            st_q <= S_WAIT2;
          end
        end
        S_WAIT2: begin
          if (kind_q == 2'h2) begin
            st_q <= S_WAIT3;
          end else begin
            rsp_q <= bus.rdata;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        // Fetched code lands one cycle after the array answers
        S_WAIT3: st_q <= S_WAIT4;
        S_WAIT4: begin
          rsp_q <= bus.code_data;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.code_rd = crd_q;
  assign bus.code_addr = addr_q;
  assign done = done_q;
  assign rsp_data = rsp_q;
  assign irq_seen = irq_q;
endmodule // fcp_host
`default_nettype wire

/* tb/fcp_asserts.sv */
/*
  Concurrent checks on the link between host and protection device.
  Assumes one clock domain and the link signals wired in by name.
*/
`timescale 1ns/1ns
`default_nettype none
module fcp_asserts
  import fcp_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Link
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        code_rd,
  input wire logic [15:0] code_addr,
  input wire logic [7:0]  code_data,
  input wire logic        irq
);
  logic [7:0]  high_q, lz_q, uz_q, mask_q, lo_q;
  logic [6:0]  hi_q;
  logic        rlo_q, rhi_q, arm_q, wrote_q, lock_q;
  logic [4:0]  blk;
  wire         rng_wr = wr && ((addr == FCP_ADDR_GUARD_LO && wdata != 8'h00) ||
                               (addr == FCP_ADDR_GUARD_HI && wdata[6:0] != 7'h00));
  wire         en_wr  = wr && addr == FCP_ADDR_GUARD_HI && wdata == FCP_UPD_EN_WORD;
  wire [14:0]  seen   = {hi_q, lo_q};
  // Guard bits are learnt only from read-back, so blk never lies below the true start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_q  <= FCP_RST_ZERO;
      lz_q    <= FCP_RST_LZONE;
      uz_q    <= FCP_RST_UZONE;
      mask_q  <= FCP_RST_ZERO;
      lo_q    <= FCP_RST_ZERO;
      hi_q    <= 7'h00;
      rlo_q   <= 1'b0;
      rhi_q   <= 1'b0;
      arm_q   <= 1'b0;
      wrote_q <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      if (wr && addr == FCP_ADDR_HIGH) high_q <= wdata;
      if (wr && addr == FCP_ADDR_LZONE) lz_q <= wdata;
      if (wr && addr == FCP_ADDR_UZONE) uz_q <= wdata;
      if (wr && addr == FCP_ADDR_IMASK) mask_q <= wdata;
      if (rlo_q) lo_q <= rdata;
      if (rhi_q) hi_q <= rdata[6:0];
      if ((rlo_q && rdata != 8'h00) || (rhi_q && rdata[6:0] != 7'h00)) lock_q <= 1'b1;
      if (rng_wr) wrote_q <= 1'b1;
      arm_q   <= !rng_wr && (arm_q || (en_wr && !wrote_q));
      rlo_q   <= rd && addr == FCP_ADDR_GUARD_LO;
      rhi_q   <= rd && addr == FCP_ADDR_GUARD_HI;
    end
  end
  always_comb begin
    blk = 5'd16;
    for (int i = 14; i >= 0; i--) begin
      if (seen[i]) blk = 5'(i + 1);
    end
  end
  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_high_byte: assert property (rd && addr == FCP_ADDR_HIGH |=> rdata == high_q)
    else $error("high address byte read back wrong");
  chk_low_zone: assert property (rd && addr == FCP_ADDR_LZONE |=> rdata == lz_q)
    else $error("lower zone boundary read back wrong");
  chk_up_zone: assert property (rd && addr == FCP_ADDR_UZONE |=> rdata == uz_q)
    else $error("upper zone boundary read back wrong");
  chk_lo_set_only: assert property (rlo_q |-> (rdata & lo_q) == lo_q)
    else $error("low guard bit was cleared");
  chk_hi_set_only: assert property (rhi_q |-> (rdata[6:0] & hi_q) == hi_q)
    else $error("high guard bit was cleared");
  chk_enable_arm: assert property (rd && addr == FCP_ADDR_GUARD_HI && arm_q |=> rdata[FCP_UPD_EN_BIT])
    else $error("update enable not set");
  chk_enable_lock: assert property (rd && addr == FCP_ADDR_GUARD_HI && lock_q |=> !rdata[FCP_UPD_EN_BIT])
    else $error("update enable not locked");
  chk_guard_fetch: assert property (code_rd && {1'b0, code_addr[15:12]} >= blk |-> ##3 code_data == 8'h00)
    else $error("guarded fetch returned data");
  chk_fail_irq: assert property (wr && addr == FCP_ADDR_CMD && wdata[1] && lz_q == FCP_RST_LZONE
                                 && high_q != FCP_TOP_PAGE && mask_q[FCP_ST_FAIL] |-> ##[1:3] irq)
    else $error("blocked command raised no interrupt");
  cov_guard_fetch: cover property (code_rd && {1'b0, code_addr[15:12]} >= blk);
  cov_locked: cover property (rd && addr == FCP_ADDR_GUARD_HI && lock_q);
  cov_irq: cover property ($rose(irq));
endmodule // fcp_asserts
`default_nettype wire

/* tb/flash_content_protection_tb.sv */
/*
  Self-checking bench: host and device joined by the interface, table cases,
  then interrupt, zone, guard and reset cases.
  Assumes the flash array answers one cycle after its read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_content_protection_tb;
  import fcp_pkg::*;
  typedef struct packed {logic [1:0] k; logic [15:0] a; logic [7:0] d; logic [7:0] e;} fcp_row_type;
  logic        clock, reset_n, req, done, irq_seen, fl_rd, fl_wr, fl_erase;
  logic [1:0]  kind;
  logic [15:0] req_addr;
  logic [7:0]  req_wdata, rsp_data, fl_wdata, fl_rdata, r, prog_data;
  logic [23:0] fl_addr, prog_addr;
  int          error_cnt = 0, n_tests = 0, n_prog = 0, base;
  fcp_row_type rows [13] = '{'{2'h1, FCP_ADDR_LZONE, 8'h00, 8'hFF}, '{2'h1, FCP_ADDR_UZONE, 8'h00, 8'h00},
    '{2'h1, FCP_ADDR_HIGH, 8'h00, 8'h00}, '{2'h1, FCP_ADDR_TOP, 8'h00, 8'h00},
    '{2'h1, FCP_ADDR_GUARD_LO, 8'h00, 8'h00}, '{2'h1, FCP_ADDR_GUARD_HI, 8'h00, 8'h00},
    '{2'h0, FCP_ADDR_HIGH, 8'h5A, 8'h00}, '{2'h1, FCP_ADDR_HIGH, 8'h00, 8'h5A},
    '{2'h0, FCP_ADDR_HIGH, 8'hA5, 8'h00}, '{2'h1, FCP_ADDR_HIGH, 8'h00, 8'hA5},
    '{2'h0, FCP_ADDR_UZONE, 8'h3C, 8'h00}, '{2'h1, FCP_ADDR_UZONE, 8'h00, 8'h3C}, '{2'h1, 16'hA030, 8'h00, 8'h00}};
  logic [24:0] zones [6] = '{{24'h000FFF, 1'b1}, {24'h001000, 1'b0}, {24'h007FFF, 1'b0},
                             {24'h008000, 1'b1}, {24'h010000, 1'b1}, {24'h00FF00, 1'b1}};
  // ****************************************************
  // Design and flash array
  // ****************************************************
  fcp_if fcp_if_inst (.clock(clock), .reset_n(reset_n));
  fcp_host fcp_host_inst (.clock(clock), .reset_n(reset_n), .bus(fcp_if_inst), .req(req), .kind(kind),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rsp_data(rsp_data), .irq_seen(irq_seen));
  fcp_device fcp_device_inst (.clock(clock), .reset_n(reset_n), .bus(fcp_if_inst), .fl_rd(fl_rd), .fl_wr(fl_wr),
    .fl_erase(fl_erase), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));
  fcp_asserts fcp_asserts_inst (.clock(clock), .reset_n(reset_n), .addr(fcp_if_inst.addr),
    .wdata(fcp_if_inst.wdata), .wr(fcp_if_inst.wr), .rd(fcp_if_inst.rd), .rdata(fcp_if_inst.rdata),
    .code_rd(fcp_if_inst.code_rd), .code_addr(fcp_if_inst.code_addr), .code_data(fcp_if_inst.code_data),
    .irq(fcp_if_inst.irq));
  // Array data is stale-inverted outside the answer cycle so a late sample cannot pass
  always @(posedge clock) begin
    fl_rdata <= fl_rd ? fl_addr[7:0] ^ 8'h5A : ~fl_rdata;
    if (fl_wr || fl_erase) begin
      n_prog <= n_prog + 1;
      prog_addr <= fl_addr;
      prog_data <= fl_wdata;
    end
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    req <= 1'b1;
    kind <= k;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clock);
    req <= 1'b0;
    for (i = 0; i < 16; i++) begin
      @(negedge clock);
      if (k == 2'h2 ? i == 4 : done === 1'b1) break;
    end
    if (i == 16) cmp_bit("done", 1'b1, 1'b0);
    r = rsp_data;
  endtask
  task automatic reg_rd(input string what, input logic [15:0] a, input logic [7:0] e);
    op(2'h1, a, 8'h00);
    cmp(what, e, r);
  endtask
  task automatic fetch(input logic [15:0] a, input logic [7:0] e);
    op(2'h2, a, 8'h00);
    cmp("code data", e, r);
  endtask
  task automatic cmd(input logic [23:0] a, input logic [1:0] c);
    base = n_prog;
    op(2'h0, FCP_ADDR_TOP, a[23:16]);
    op(2'h0, FCP_ADDR_HIGH, a[15:8]);
    op(2'h0, FCP_ADDR_LOW, a[7:0]);
    op(2'h0, FCP_ADDR_CMD, {6'h00, c});
  endtask
  task automatic irq_chk(input logic [15:0] a, input logic [7:0] d, input logic e);
    op(2'h0, a, d);
    repeat (3) @(negedge clock);
    cmp_bit("irq", e, irq_seen);
  endtask
  task automatic do_reset;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    reset_n = 1'b0;
    req = 1'b0;
    kind = 2'h0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k == 2'h1) cmp("table read", rows[i].e, r);
    end
    $display("table cases done");
    irq_chk(FCP_ADDR_IMASK, 8'h02, 1'b0);
    cmd(24'h004000, FCP_CMD_WRITE);
    op(2'h1, FCP_ADDR_STAT, 8'h00);
    cmp_bit("fail status", 1'b1, r[FCP_ST_FAIL]);
    cmp("program count", 8'h00, 8'(n_prog - base));
    cmp_bit("irq", 1'b1, irq_seen);
    irq_chk(FCP_ADDR_IMASK, 8'h00, 1'b0);
    irq_chk(FCP_ADDR_IMASK, 8'h01, 1'b1);
    irq_chk(FCP_ADDR_STAT, 8'h03, 1'b0);
    $display("interrupt cases done");
    op(2'h0, FCP_ADDR_DATA, 8'hC3);
    op(2'h0, FCP_ADDR_LZONE, 8'h10);
    op(2'h0, FCP_ADDR_UZONE, 8'h7E);
    foreach (zones[j]) begin
      cmd(zones[j][24:1], j[0] ? FCP_CMD_ERASE : FCP_CMD_WRITE);
      op(2'h1, FCP_ADDR_RESULT, 8'h00);
      cmp_bit("result", zones[j][0], r[0]);
      cmp("program count", {7'h00, !zones[j][0]}, 8'(n_prog - base));
    end
    cmp("program address", 8'h7F, prog_addr[15:8]);
    cmp("program data", 8'hC3, prog_data);
    cmd(24'h001234, FCP_CMD_READ);
    reg_rd("read data", FCP_ADDR_DATA, 8'h34 ^ 8'h5A);
    $display("zone cases done");
    op(2'h0, FCP_ADDR_GUARD_LO, 8'h02);
    reg_rd("guard low", FCP_ADDR_GUARD_LO, 8'h00);
    do_reset;
    reg_rd("lower zone", FCP_ADDR_LZONE, 8'hFF);
    op(2'h0, FCP_ADDR_GUARD_HI, FCP_UPD_EN_WORD);
    reg_rd("guard high", FCP_ADDR_GUARD_HI, 8'h80);
    op(2'h0, FCP_ADDR_GUARD_LO, 8'h02);
    reg_rd("guard high", FCP_ADDR_GUARD_HI, 8'h00);
    fetch(16'h1FFF, 8'hA5);
    fetch(16'h2000, 8'h00);
    do_reset;
    reg_rd("guard low", FCP_ADDR_GUARD_LO, 8'h00);
    op(2'h0, FCP_ADDR_GUARD_HI, FCP_UPD_EN_WORD);
    op(2'h0, FCP_ADDR_GUARD_HI, 8'h41);
    reg_rd("guard high", FCP_ADDR_GUARD_HI, 8'h41);
    op(2'h0, FCP_ADDR_GUARD_HI, 8'h00);
    op(2'h0, FCP_ADDR_GUARD_HI, FCP_UPD_EN_WORD);
    op(2'h0, FCP_ADDR_GUARD_LO, 8'h01);
    reg_rd("guard high", FCP_ADDR_GUARD_HI, 8'h41);
    reg_rd("guard low", FCP_ADDR_GUARD_LO, 8'h00);
    fetch(16'h8FFF, 8'hA5);
    fetch(16'h9000, 8'h00);
    fetch(16'hF123, 8'h00);
    cmd(24'h00A000, FCP_CMD_READ);
    reg_rd("read data", FCP_ADDR_DATA, 8'h00);
    $display("guard cases done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    cmp_bit("watchdog", 1'b1, 1'b0);
    results();
  end
endmodule // flash_content_protection_tb
`default_nettype wire
